// ===== bench/rcip_checker.sv
/*
 * Port checker for the system pin control top: bus, bus clock and reset pin timing.
 * Assumes it is bound to rcip_top and shares its single clock and reset.
 */
module rcip_checker (
	input logic       clk_i,
	input logic       rst_i,
	input logic       wb_cyc_i,
	input logic       wb_stb_i,
	input logic       wb_ack_o,
	input logic       bus_clock_out_o,
	input logic       bus_clock_oe_o,
	input logic       stop_i,
	input logic       slow_access_i,
	input logic       reset_pin_n_i,
	input logic       reset_pin_o,
	input logic       reset_pin_oe_o,
	input logic [1:0] mode_pins_i,
	input logic       wdog_fail_i,
	input logic       clkmon_fail_i,
	input logic       core_reset_o,
	input logic [1:0] vector_sel_o,
	input logic       irq_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Single domain, checks paused during reset
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Relations between causes at the inputs and the outputs
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	property p_half; !stop_i && !slow_access_i && bus_clock_out_o |=> !bus_clock_out_o; endproperty
	property p_stop; stop_i |-> ##2 !bus_clock_out_o; endproperty
	property p_per; mode_pins_i == 2'h2 && !core_reset_o |-> !bus_clock_oe_o; endproperty
	property p_odrain; reset_pin_oe_o |-> !reset_pin_o; endproperty
	property p_drive; $rose(reset_pin_oe_o) |-> reset_pin_oe_o[*8] ##1 reset_pin_oe_o[*8] ##1 !reset_pin_oe_o; endproperty
	property p_cause; $rose(reset_pin_oe_o) |-> $past(wdog_fail_i) || $past(clkmon_fail_i); endproperty
	property p_vec; $fell(reset_pin_oe_o) ##1 reset_pin_n_i[*8] |-> ##[1:4] vector_sel_o != 2'h0; endproperty
	property p_async; !reset_pin_n_i |-> core_reset_o; endproperty
	property p_exit; $rose(reset_pin_n_i) |-> core_reset_o ##1 core_reset_o ##[1:3] !core_reset_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	a_half: assert property (p_half) else $error("bus clock not at half rate");
	a_stop: assert property (p_stop) else $error("bus clock runs in stop");
	a_per: assert property (p_per) else $error("bus clock driven in peripheral mode");
	a_odrain: assert property (p_odrain) else $error("reset pin driven high");
	a_drive: assert property (p_drive) else $error("reset pin drive length wrong");
	a_cause: assert property (p_cause) else $error("reset pin driven without failure");
	a_vec: assert property (p_vec) else $error("internal vector not taken");
	a_async: assert property (p_async) else $error("low pin without core reset");
	a_exit: assert property (p_exit) else $error("core reset exit timing wrong");
	// Main scenarios reached
	c_drive: cover property ($rose(reset_pin_oe_o));
	c_ack: cover property (wb_ack_o);
	c_irq: cover property ($rose(irq_req_o));
endmodule : rcip_checker

// ===== bench/rcip_partner.sv
/*
 * Far side model: external reset circuit with pull-up, interrupt source, bus clock source.
 * Assumes the bench clock and a one-cycle command for each external reset.
 */
module rcip_partner (
	input  wire logic clk_i,
	input  wire logic pin_oe_i,
	input  wire logic pin_val_i,
	input  wire logic ext_req_i,
	input  wire logic irq_src_i,
	output logic      reset_pin_n_o,
	output logic      irq_pin_n_o,
	output logic      bus_clock_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] hold_ff = 6'h00;
	logic       bclk_ff = 1'b0;
	// External reset holds the pin low for 32 cycles
	always_ff @(posedge clk_i) begin
		if (ext_req_i) begin
			hold_ff <= 6'h20;
		end else if (hold_ff != 6'h00) begin
			hold_ff <= hold_ff - 6'h01;
		end
	end
	// Bus clock supplied from outside
	always_ff @(posedge clk_i) begin
		bclk_ff <= ~bclk_ff;
	end
	// Wired levels: any open-drain party pulls low, pull-up otherwise
	assign reset_pin_n_o = ~((pin_oe_i & ~pin_val_i) | (hold_ff != 6'h00));
	assign irq_pin_n_o   = ~irq_src_i;
	assign bus_clock_o   = bclk_ff;
endmodule : rcip_partner

// ===== bench/tb_rcip_top.sv
/*
 * Self-checking bench for the system pin control top.
 * Assumes the defines header on the include path and the partner model beside it.
 */
`include "rcip_defines.svh"
module tb_rcip_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, int_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        bus_clock_in_i, bus_clock_out_o, bus_clock_oe_o, reset_pin_n_i, reset_pin_o, reset_pin_oe_o;
	logic [1:0]  mode_pins_i, vector_sel_o;
	logic        stop_i, slow_access_i, wdog_fail_i, clkmon_fail_i, irq_ack_i, core_reset_o, irq_req_o;
	logic        irq_pin_n_i, ext_req, irq_src;
	int          n_errors, checks, hn;
	rcip_top u_rcip_top (.*);
	rcip_partner u_rcip_partner (.clk_i(clk_i), .pin_oe_i(reset_pin_oe_o), .pin_val_i(reset_pin_o),
		.ext_req_i(ext_req), .irq_src_i(irq_src), .reset_pin_n_o(reset_pin_n_i),
		.irq_pin_n_o(irq_pin_n_i), .bus_clock_o(bus_clock_in_i));
	// Clock at 25 MHz
	always #20 clk_i = ~clk_i;
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task stop_test;
		$display("errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	// Classic single cycle; read data lands in q
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) n_errors++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	// Cycles of one bus clock half period, 40 if it stands still
	task half;
		logic v;
		repeat (2) @(negedge clk_i);
		for (int i = 0; i < 2; i++) begin
			v = bus_clock_out_o;
			hn = 0;
			do begin
				@(negedge clk_i);
				hn++;
			end while (bus_clock_out_o === v && hn < 40);
		end
	endtask : half
	task do_reset(input logic [1:0] m);
		@(posedge clk_i);
		rst_i         <= 1'b1;
		mode_pins_i   <= m;
		stop_i        <= 1'b0;
		slow_access_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : do_reset
	task t_mode0;
		do_reset(2'h0);
		wb(1'b0, `RCIP_OFS_CTRL, 32'h0);
		chk(q, 32'h4);
		chk(bus_clock_oe_o, 1'b1);
		half;
		chk(hn, 40);
		wb(1'b1, `RCIP_OFS_CTRL, 32'h1);
		half;
		chk(hn, 1);
		@(posedge clk_i);
		stop_i <= 1'b1;
		half;
		chk(hn, 40);
		@(posedge clk_i);
		stop_i        <= 1'b0;
		slow_access_i <= 1'b1;
		wb(1'b1, `RCIP_OFS_CTRL, 32'h21);
		half;
		chk(hn, 3);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
	endtask : t_mode0
	task t_modes;
		do_reset(2'h1);
		wb(1'b0, `RCIP_OFS_CTRL, 32'h0);
		chk(q, 32'h5);
		half;
		chk(hn, 1);
		wb(1'b1, `RCIP_OFS_CTRL, 32'h4);
		half;
		chk(hn, 40);
		do_reset(2'h2);
		wb(1'b0, `RCIP_OFS_STATUS, 32'h0);
		chk(q[2:1], 2'h2);
		hn = q[3];
		wb(1'b0, `RCIP_OFS_STATUS, 32'h0);
		chk(q[3], !hn[0]);
		chk(bus_clock_oe_o, 1'b0);
	endtask : t_modes
	task t_irq;
		do_reset(2'h0);
		irq_src <= 1'b1;
		repeat (6) @(negedge clk_i);
		chk(irq_req_o, 1'b0);
		wb(1'b0, `RCIP_OFS_STATUS, 32'h0);
		chk(q[0], 1'b0);
		wb(1'b1, `RCIP_OFS_CTRL, 32'h0);
		@(negedge clk_i);
		chk(irq_req_o, 1'b1);
		@(posedge clk_i);
		irq_src <= 1'b0;
		@(negedge clk_i);
		chk(irq_req_o, 1'b1);
		repeat (4) @(negedge clk_i);
		chk(irq_req_o, 1'b0);
		wb(1'b1, `RCIP_OFS_CTRL, 32'h2);
		irq_src <= 1'b1;
		@(posedge clk_i);
		irq_src <= 1'b0;
		repeat (5) @(negedge clk_i);
		chk(irq_req_o, 1'b1);
		@(posedge clk_i);
		irq_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_ack_i <= 1'b0;
		repeat (2) @(negedge clk_i);
		chk(irq_req_o, 1'b0);
	endtask : t_irq
	// Internal failure, optionally with an external reset at once
	task int_rst(input logic wd, cm, ex, input logic [2:0] m, input logic [1:0] v, input logic [31:0] ev,
		input logic ie);
		int n;
		wb(1'b1, `RCIP_OFS_EVT_MASK, {29'h0, m});
		@(posedge clk_i);
		wdog_fail_i   <= wd;
		clkmon_fail_i <= cm;
		ext_req       <= ex;
		@(posedge clk_i);
		wdog_fail_i   <= 1'b0;
		clkmon_fail_i <= 1'b0;
		ext_req       <= 1'b0;
		n = 0;
		while (reset_pin_oe_o !== 1'b1 && n < 9) begin
			@(negedge clk_i);
			n++;
		end
		n = 0;
		while (reset_pin_oe_o === 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		chk(n, 16);
		repeat (24) @(negedge clk_i);
		chk(vector_sel_o, v);
		wb(1'b0, `RCIP_OFS_EVT, 32'h0);
		chk(q, ev);
		chk(int_o, ie);
		wb(1'b1, `RCIP_OFS_EVT, ev);
		@(negedge clk_i);
		chk(int_o, 1'b0);
	endtask : int_rst
	// Inputs at time zero, then the scenarios
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, stop_i, slow_access_i, wdog_fail_i, clkmon_fail_i} = 7'h00;
		{irq_ack_i, ext_req, irq_src, mode_pins_i, wb_adr_i, wb_dat_i} = 45'h0;
		wb_sel_i = 4'hF;
		n_errors = 0;
		checks = 0;
		t_mode0;
		t_modes;
		t_irq;
		int_rst(1'b1, 1'b0, 1'b0, 3'h7, 2'h1, 32'h1, 1'b1);
		int_rst(1'b0, 1'b1, 1'b0, 3'h1, 2'h2, 32'h2, 1'b0);
		int_rst(1'b0, 1'b1, 1'b1, 3'h7, 2'h0, 32'h4, 1'b1);
		stop_test;
	end
	// Hang guard at 10000 cycles, well beyond the few hundred cycles the tests need
	initial begin
		#400000;
		n_errors++;
		stop_test;
	end
endmodule : tb_rcip_top
bind rcip_top rcip_checker u_rcip_checker (.*);

// ===== verilog/rcip_defines.svh
/*
 * Offsets, field positions, mode strap codes and counts of the system pin control block.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef RCIP_DEFINES_SVH
`define RCIP_DEFINES_SVH

// Register byte offsets
`define RCIP_OFS_CTRL      8'h00
`define RCIP_OFS_STATUS    8'h04
`define RCIP_OFS_EVT       8'h08
`define RCIP_OFS_EVT_MASK  8'h0C
`define RCIP_ADDR_W        8

// Control register fields
`define RCIP_CTRL_BCLK_EN  0
`define RCIP_CTRL_EDGE     1
`define RCIP_CTRL_IMASK    2
`define RCIP_CTRL_STR_LO   4
`define RCIP_CTRL_STR_HI   7

// Status register fields
`define RCIP_ST_IRQ_PIN    0
`define RCIP_ST_MODE_LO    1
`define RCIP_ST_MODE_HI    2
`define RCIP_ST_BCLK_IN    3
`define RCIP_ST_VEC_LO     4
`define RCIP_ST_VEC_HI     5
`define RCIP_ST_IRQ_REQ    6

// Event register fields
`define RCIP_EV_WDOG       0
`define RCIP_EV_CLKMON     1
`define RCIP_EV_EXT        2
`define RCIP_EV_W          3

// Mode strap codes
`define RCIP_MODE_NSC      2'h0
`define RCIP_MODE_SSC      2'h1
`define RCIP_MODE_SPER     2'h2

// Reset pin sequence counts, in internal clock cycles
`define RCIP_DRIVE_CYC     16
`define RCIP_SAMPLE_DLY    8
`define RCIP_CNT_W         5

`endif

// ===== verilog/rcip_pkg.sv
/*
 * Types of the system pin control block.
 * Assumes the defines header is on the include path.
 */
`include "rcip_defines.svh"

package rcip_pkg;

	typedef logic [1:0] rcip_mode_t;

	// Internal reset pin sequencer
	typedef enum logic [1:0] {
		RCIP_IDLE,
		RCIP_DRIVE,
		RCIP_WAIT,
		RCIP_SAMPLE
	} rcip_seq_e;

	// Reset vector chosen after the last reset
	typedef enum logic [1:0] {
		RCIP_VEC_RESET,
		RCIP_VEC_WDOG,
		RCIP_VEC_CLKMON
	} rcip_vec_e;

endpackage : rcip_pkg

// ===== verilog/rcip_top.sv
/*
 * System pin control: bus clock output, bidirectional reset pin sequencer,
 * maskable interrupt pin conditioning, and a classic Wishbone register slave.
 * Assumes clk_i is the internal clock derived from the oscillator input, and that
 * pin inputs (reset pin, interrupt pin, mode straps, bus clock pin) are asynchronous.
 */
// The register addresses and the Wishbone interface to the registers were left to the implementer.
// Summary of operation
// - When enabled, the bus clock output toggles at half the internal clock rate.
// - In normal single-chip mode the bus clock output is off when reset ends and software can turn it on.
// - In special single-chip mode the bus clock output is on when reset ends and software can turn it off.
// - In special peripheral mode the bus clock pin is an input fed by the outside party.
// - In stop mode the bus clock output is halted.
// - Software can stretch the bus clock during slow external accesses.
// - The reset pin enters reset without a clock and leaves it in step with the internal clock.
// - A watchdog or clock monitor failure pulls the reset pin low through an open-drain driver.
// - An internal reset drives the pin low for 16 cycles, releases it, and samples it 8 cycles later.
// - A high sample selects the watchdog or clock monitor vector, a low sample the reset vector.
// - A control bit selects falling edge or low level triggering of the interrupt pin.
// - Reset selects level triggering of the interrupt pin.
// - Reset sets the interrupt mask so interrupt pin requests are ignored until software clears it.
// - The interrupt pin is always an input whose level software can read.
`include "rcip_defines.svh"
module rcip_top
	import rcip_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             int_o,
	// Bus clock pin
	input  wire logic        bus_clock_in_i,
	output logic             bus_clock_out_o,
	output logic             bus_clock_oe_o,
	// Reset pin, active low, open drain
	input  wire logic        reset_pin_n_i,
	output logic             reset_pin_o,
	output logic             reset_pin_oe_o,
	// Mode straps
	input  wire logic [1:0]  mode_pins_i,
	// Core side
	input  wire logic        stop_i,
	input  wire logic        slow_access_i,
	input  wire logic        wdog_fail_i,
	input  wire logic        clkmon_fail_i,
	input  wire logic        irq_ack_i,
	output logic             core_reset_o,
	output logic [1:0]       vector_sel_o,
	output logic             irq_req_o,
	// Maskable interrupt pin, active low
	input  wire logic        irq_pin_n_i
);

	localparam int STR_W = `RCIP_CTRL_STR_HI - `RCIP_CTRL_STR_LO + 1;

	// Byte-lane write merge for the low byte of a register
	function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [31:0] dat,
	                                          input logic [3:0] sel);
		lane_merge = sel[0] ? dat[7:0] : old_v;
	endfunction : lane_merge

	// Synchronisers
	logic             irq_s1_ff;
	logic             irq_s2_ff;
	logic             irq_d_ff;
	logic             rpin_s1_ff;
	logic             rpin_s2_ff;
	logic             bin_s1_ff;
	logic             bin_s2_ff;
	logic [1:0]       mode_s1_ff;
	logic [1:0]       mode_s2_ff;
	logic             arst_a_ff;
	logic             arst_b_ff;

	// Control and state
	rcip_mode_t       mode_ff;
	logic             bclk_en_ff;
	logic             edge_mode_ff;
	logic             imask_ff;
	logic [STR_W-1:0] stretch_ff;
	logic [STR_W-1:0] phase_cnt_ff;
	logic             bclk_ff;
	rcip_seq_e        seq_ff;
	rcip_seq_e        nxt_seq;
	logic [`RCIP_CNT_W-1:0] seq_cnt_ff;
	logic             cause_clkmon_ff;
	rcip_vec_e        vec_ff;
	logic             edge_pend_ff;
	logic [`RCIP_EV_W-1:0] evt_ff;
	logic [`RCIP_EV_W-1:0] evt_mask_ff;
	logic [`RCIP_EV_W-1:0] evt_set;
	logic             ext_seen_ff;

	logic             wb_req;
	logic             wb_wr;
	logic             bclk_run;
	logic [STR_W-1:0] phase_lim;
	logic             samp_done;
	logic [7:0]       mask_merged;

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_req & wb_we_i;

	// Reset pin: asynchronous entry, release in step with the clock; own drive feeds back via the wire
	always_ff @(posedge clk_i or negedge reset_pin_n_i) begin
		if (!reset_pin_n_i) begin
			arst_a_ff    <= 1'b1;
			arst_b_ff    <= 1'b1;
			core_reset_o <= 1'b1;
		end else begin
			arst_a_ff    <= 1'b0;
			arst_b_ff    <= arst_a_ff;
			core_reset_o <= arst_b_ff | rst_i;
		end
	end

	// Two-flop synchronisers for pin inputs
	always_ff @(posedge clk_i) begin
		irq_s1_ff  <= irq_pin_n_i;
		irq_s2_ff  <= irq_s1_ff;
		rpin_s1_ff <= reset_pin_n_i;
		rpin_s2_ff <= rpin_s1_ff;
		bin_s1_ff  <= bus_clock_in_i;
		bin_s2_ff  <= bin_s1_ff;
		mode_s1_ff <= mode_pins_i;
		mode_s2_ff <= mode_s1_ff;
	end

	// Straps are caught during system reset too: the enable reload at reset exit reads mode_ff
	always_ff @(posedge clk_i) begin
		if (rst_i || core_reset_o) begin
			mode_ff <= mode_s2_ff;
		end
	end

	// Control register: bus clock enable, trigger select, interrupt mask, stretch count
	always_ff @(posedge clk_i) begin
		if (rst_i || core_reset_o) begin
			bclk_en_ff   <= (mode_ff == `RCIP_MODE_SSC);
			edge_mode_ff <= 1'b0;
			imask_ff     <= 1'b1;
			stretch_ff   <= '0;
		end else if (wb_wr && wb_adr_i == `RCIP_OFS_CTRL && wb_sel_i[0]) begin
			bclk_en_ff   <= wb_dat_i[`RCIP_CTRL_BCLK_EN];
			edge_mode_ff <= wb_dat_i[`RCIP_CTRL_EDGE];
			imask_ff     <= wb_dat_i[`RCIP_CTRL_IMASK];
			stretch_ff   <= wb_dat_i[`RCIP_CTRL_STR_HI:`RCIP_CTRL_STR_LO];
		end
	end

	// Bus clock generator: halt when disabled, stopped, or in peripheral mode
	assign bclk_run  = bclk_en_ff & ~stop_i & (mode_ff != `RCIP_MODE_SPER);
	assign phase_lim = slow_access_i ? stretch_ff : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i || !bclk_run) begin
			bclk_ff      <= 1'b0;
			phase_cnt_ff <= '0;
		end else if (phase_cnt_ff >= phase_lim) begin
			bclk_ff      <= ~bclk_ff;
			phase_cnt_ff <= '0;
		end else begin
			phase_cnt_ff <= phase_cnt_ff + 1'b1;
		end
	end

	// Bus clock pin drive; released to an input in peripheral mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_clock_out_o <= 1'b0;
			bus_clock_oe_o  <= 1'b0;
		end else begin
			bus_clock_out_o <= bclk_ff;
			bus_clock_oe_o  <= (mode_ff != `RCIP_MODE_SPER);
		end
	end

	// Internal reset sequencer next state
	always_comb begin
		nxt_seq = seq_ff;
		case (seq_ff)
			RCIP_IDLE: begin
				if (wdog_fail_i || clkmon_fail_i) begin
					nxt_seq = RCIP_DRIVE;
				end
			end
			RCIP_DRIVE: begin
				if (seq_cnt_ff == `RCIP_CNT_W'(`RCIP_DRIVE_CYC - 1)) begin
					nxt_seq = RCIP_WAIT;
				end
			end
			RCIP_WAIT: begin
				if (seq_cnt_ff == `RCIP_CNT_W'(`RCIP_SAMPLE_DLY - 1)) begin
					nxt_seq = RCIP_SAMPLE;
				end
			end
			RCIP_SAMPLE: begin
				nxt_seq = RCIP_IDLE;
			end
			default: begin
				nxt_seq = RCIP_IDLE;
			end
		endcase
	end

	// Sequencer state, counter and failure cause
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_ff          <= RCIP_IDLE;
			seq_cnt_ff      <= '0;
			cause_clkmon_ff <= 1'b0;
		end else begin
			seq_ff <= nxt_seq;
			if (nxt_seq != seq_ff) begin
				seq_cnt_ff <= '0;
			end else begin
				seq_cnt_ff <= seq_cnt_ff + 1'b1;
			end
			if (seq_ff == RCIP_IDLE && (wdog_fail_i || clkmon_fail_i)) begin
				cause_clkmon_ff <= clkmon_fail_i & ~wdog_fail_i;
			end
		end
	end

	// Open-drain reset pin: only ever drives low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_pin_o    <= 1'b0;
			reset_pin_oe_o <= 1'b0;
		end else begin
			reset_pin_o    <= 1'b0;
			reset_pin_oe_o <= (nxt_seq == RCIP_DRIVE);
		end
	end

	// Vector choice at the sample point, or on an outside reset seen while idle
	assign samp_done = (seq_ff == RCIP_SAMPLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vec_ff      <= RCIP_VEC_RESET;
			ext_seen_ff <= 1'b0;
		end else begin
			ext_seen_ff <= (seq_ff == RCIP_IDLE) & ~rpin_s2_ff;
			if (samp_done) begin
				if (rpin_s2_ff) begin
					vec_ff <= cause_clkmon_ff ? RCIP_VEC_CLKMON : RCIP_VEC_WDOG;
				end else begin
					vec_ff <= RCIP_VEC_RESET;
				end
			end else if (seq_ff == RCIP_IDLE && !rpin_s2_ff) begin
				vec_ff <= RCIP_VEC_RESET;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vector_sel_o <= 2'h0;
		end else begin
			vector_sel_o <= vec_ff;
		end
	end

	// Interrupt pin: falling edge latch or low level, gated by the mask
	always_ff @(posedge clk_i) begin
		if (rst_i || core_reset_o) begin
			irq_d_ff     <= 1'b1;
			edge_pend_ff <= 1'b0;
			irq_req_o    <= 1'b0;
		end else begin
			irq_d_ff <= irq_s2_ff;
			if (irq_d_ff && !irq_s2_ff) begin
				edge_pend_ff <= 1'b1;
			end else if (irq_ack_i || !edge_mode_ff) begin
				edge_pend_ff <= 1'b0;
			end
			irq_req_o <= ~imask_ff & (edge_mode_ff ? edge_pend_ff : ~irq_s2_ff);
		end
	end

	// Sticky events; a new event wins over a clear in the same cycle
	assign evt_set[`RCIP_EV_WDOG]   = samp_done & rpin_s2_ff & ~cause_clkmon_ff;
	assign evt_set[`RCIP_EV_CLKMON] = samp_done & rpin_s2_ff & cause_clkmon_ff;
	assign evt_set[`RCIP_EV_EXT]    = (samp_done & ~rpin_s2_ff)
	                                | ((seq_ff == RCIP_IDLE) & ~rpin_s2_ff & ~ext_seen_ff);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_ff <= '0;
		end else if (wb_wr && wb_adr_i == `RCIP_OFS_EVT && wb_sel_i[0]) begin
			evt_ff <= (evt_ff & ~wb_dat_i[`RCIP_EV_W-1:0]) | evt_set;
		end else begin
			evt_ff <= evt_ff | evt_set;
		end
	end

	// Event mask, written through the low byte lane only
	assign mask_merged = lane_merge({5'h00, evt_mask_ff}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_mask_ff <= '0;
		end else if (wb_wr && wb_adr_i == `RCIP_OFS_EVT_MASK) begin
			evt_mask_ff <= mask_merged[`RCIP_EV_W-1:0];
		end
	end

	// Interrupt output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_o <= 1'b0;
		end else begin
			int_o <= |(evt_ff & evt_mask_ff);
		end
	end

	// Wishbone answer: one wait-free ack per request, zero for unmapped reads
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`RCIP_OFS_CTRL: begin
						wb_dat_o[`RCIP_CTRL_BCLK_EN]                   <= bclk_en_ff;
						wb_dat_o[`RCIP_CTRL_EDGE]                      <= edge_mode_ff;
						wb_dat_o[`RCIP_CTRL_IMASK]                     <= imask_ff;
						wb_dat_o[`RCIP_CTRL_STR_HI:`RCIP_CTRL_STR_LO] <= stretch_ff;
					end
					`RCIP_OFS_STATUS: begin
						wb_dat_o[`RCIP_ST_IRQ_PIN]                   <= irq_s2_ff;
						wb_dat_o[`RCIP_ST_MODE_HI:`RCIP_ST_MODE_LO] <= mode_ff;
						wb_dat_o[`RCIP_ST_BCLK_IN]                   <= bin_s2_ff;
						wb_dat_o[`RCIP_ST_VEC_HI:`RCIP_ST_VEC_LO]   <= vec_ff;
						wb_dat_o[`RCIP_ST_IRQ_REQ]                   <= irq_req_o;
					end
					`RCIP_OFS_EVT: begin
						wb_dat_o[`RCIP_EV_W-1:0] <= evt_ff;
					end
					`RCIP_OFS_EVT_MASK: begin
						wb_dat_o[`RCIP_EV_W-1:0] <= evt_mask_ff;
					end
					default: begin
						wb_dat_o <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

endmodule : rcip_top
